// >>> shared/soc_pkg.sv
`default_nettype none
package soc_pkg;
    // special stream numbers
    localparam logic [15:0] SID_NOSTREAM = 16'h0000;
    localparam logic [15:0] SID_PRIME = 16'hFFFF;
    localparam logic [4:0] SEQ_MAX = 5'h1F;
    localparam logic [4:0] SEQ_ZERO = 5'h00;
    localparam logic [4:0] SEQ_ONE = 5'h01;
    localparam logic [4:0] NUMP_ZERO = 5'h00;
    localparam logic [4:0] NUMP_ONE = 5'h01;
    localparam logic [15:0] LEN_ZERO = 16'h0000;
    localparam logic [15:0] SETUP_LEN = 16'h0008;
    localparam logic DIR_CTRL = 1'b0;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_SSEL = 8'h04;
    localparam logic [7:0] REG_BUF = 8'h08;
    localparam logic [7:0] REG_EPSZ = 8'h0C;
    localparam logic [7:0] REG_STAT = 8'h10;
    localparam int CTRL_START = 0;
    localparam int CTRL_ABORT = 1;
    localparam int CTRL_ACCEPT = 2;
    localparam int CTRL_HOLD = 3;
    localparam int CTRL_RES_LO = 4;
    localparam int CTRL_READY = 6;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [1:0] RES_OK = 2'h0;
    localparam logic [1:0] RES_ERR = 2'h1;
    localparam logic [1:0] RES_BUSY = 2'h2;
    typedef enum logic [2:0] {PK_ACK, PK_NRDY, PK_ERDY, PK_STALL, PK_STATUS, PK_DP} soc_pkt_t;
    typedef struct packed {
        logic vld;
        soc_pkt_t kind;
        logic toCtrl;
        logic [15:0] streamId;
        logic pp;
        logic setup;
        logic deferred;
        logic hubDefer;
        logic err;
        logic [15:0] len;
        logic [4:0] seq;
        logic dirIn;
        logic [15:0] wLength;
    } soc_rx_t;
    typedef struct packed {
        logic vld;
        soc_pkt_t kind;
        logic toCtrl;
        logic [15:0] streamId;
        logic [4:0] numP;
        logic pp;
        logic rty;
        logic [4:0] seq;
        logic dir;
        logic [15:0] len;
    } soc_tx_t;
    function automatic logic [4:0] seqNext(input logic [4:0] s);
        seqNext = (s == SEQ_MAX) ? SEQ_ZERO : s + SEQ_ONE;
    endfunction : seqNext
endpackage : soc_pkg
`default_nettype wire

// >>> src/soc_apb_regs.sv
`default_nettype none
module soc_apb_regs (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [31:0] statusWord,
    output logic [31:0] ctrlQ,
    output logic [15:0] ssel,
    output logic [15:0] bufSpace,
    output logic [15:0] epSize,
    output logic startPulse,
    output logic abortPulse
);
    logic [31:0] ctrl_q;
    logic [15:0] ssel_q, buf_q, epsz_q;
    logic [31:0] rdata_d;
    logic hit;
    logic wrTake;
    assign wrTake = psel & penable & pready & pwrite & ~pslverr;
    assign hit = (paddr == soc_pkg::REG_CTRL) | (paddr == soc_pkg::REG_SSEL) |
        (paddr == soc_pkg::REG_BUF) | (paddr == soc_pkg::REG_EPSZ) |
        (paddr == soc_pkg::REG_STAT);
    assign rdata_d = (paddr == soc_pkg::REG_CTRL) ? ctrl_q :
        (paddr == soc_pkg::REG_SSEL) ? {16'h0000, ssel_q} :
        (paddr == soc_pkg::REG_BUF) ? {16'h0000, buf_q} :
        (paddr == soc_pkg::REG_EPSZ) ? {16'h0000, epsz_q} :
        (paddr == soc_pkg::REG_STAT) ? statusWord : 32'h0000_0000;
    assign ctrlQ = ctrl_q;
    assign ssel = ssel_q;
    assign bufSpace = buf_q;
    assign epSize = epsz_q;
    // answer in the access cycle right after setup
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~hit;
            prdata <= (psel & ~penable & ~pwrite) ? rdata_d : 32'h0000_0000;
        end
    end
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            ctrl_q <= soc_pkg::CTRL_RESET;
            ssel_q <= 16'h0000;
            buf_q <= 16'h0000;
            epsz_q <= 16'h0000;
            startPulse <= 1'b0;
            abortPulse <= 1'b0;
        end
        else
        begin
            startPulse <= wrTake & (paddr == soc_pkg::REG_CTRL) & pwdata[soc_pkg::CTRL_START];
            abortPulse <= wrTake & (paddr == soc_pkg::REG_CTRL) & pwdata[soc_pkg::CTRL_ABORT];
            if (wrTake && paddr == soc_pkg::REG_CTRL)
                ctrl_q <= pwdata & 32'h0000_007C;
            if (wrTake && paddr == soc_pkg::REG_SSEL)
                ssel_q <= pwdata[15:0];
            if (wrTake && paddr == soc_pkg::REG_BUF)
                buf_q <= pwdata[15:0];
            if (wrTake && paddr == soc_pkg::REG_EPSZ)
                epsz_q <= pwdata[15:0];
        end
    end
endmodule : soc_apb_regs
`default_nettype wire

// >>> src/soc_ctl_ep.sv
`default_nettype none
module soc_ctl_ep #(
    parameter logic [15:0] MAX_PKT = 16'h0200
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic cfg,
    input wire soc_pkg::soc_rx_t rx,
    input wire logic hold,
    input wire logic ready,
    input wire logic [1:0] result,
    input wire logic gnt,
    output soc_pkg::soc_tx_t txReq,
    output logic [2:0] stateCode
);
    typedef enum logic [1:0] {C_IDLE, C_DATA, C_STATUS, C_STALL} soc_cst_t;
    soc_cst_t st_q;
    soc_pkg::soc_tx_t tx_q;
    logic [15:0] remain_q;
    logic dirIn_q, erdyPend_q, shortSent_q;
    logic [4:0] seq_q;
    logic isSetup, isAccess, dataOver;
    logic [15:0] inLen;
    soc_cst_t stSel;
    assign isSetup = rx.vld & rx.toCtrl & (rx.kind == soc_pkg::PK_DP) & rx.setup &
        (rx.len == soc_pkg::SETUP_LEN) & (rx.seq == soc_pkg::SEQ_ZERO);
    assign isAccess = rx.vld & rx.toCtrl & ~isSetup;
    // a status tp ends the data stage and gets the status reply
    assign stSel = (st_q == C_DATA && rx.kind == soc_pkg::PK_STATUS) ? C_STATUS : st_q;
    assign inLen = (remain_q > MAX_PKT) ? MAX_PKT : remain_q;
    assign dataOver = dirIn_q ? shortSent_q : (rx.len > remain_q);
    assign stateCode = {1'b0, st_q};
    assign txReq = tx_q;
    function automatic soc_pkg::soc_tx_t mk(input soc_pkg::soc_pkt_t k, input logic [4:0] s,
        input logic [15:0] l);
        mk = '0;
        mk.vld = 1'b1;
        mk.kind = k;
        mk.toCtrl = 1'b1;
        mk.dir = soc_pkg::DIR_CTRL;
        mk.numP = soc_pkg::NUMP_ZERO;
        mk.seq = s;
        mk.len = l;
    endfunction : mk
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_q <= C_IDLE;
            tx_q <= '0;
            remain_q <= 16'h0000;
            dirIn_q <= 1'b0;
            erdyPend_q <= 1'b0;
            shortSent_q <= 1'b0;
            seq_q <= soc_pkg::SEQ_ZERO;
        end
        else if (cfg)
        begin
            st_q <= C_IDLE;
            tx_q <= '0;
            erdyPend_q <= 1'b0;
        end
        else
        begin
            if (gnt)
                tx_q.vld <= 1'b0;
            if (isSetup)
            begin
                tx_q <= mk(soc_pkg::PK_ACK, soc_pkg::SEQ_ZERO, soc_pkg::LEN_ZERO);
                dirIn_q <= rx.dirIn;
                remain_q <= rx.wLength;
                seq_q <= soc_pkg::SEQ_ZERO;
                shortSent_q <= 1'b0;
                erdyPend_q <= hold;
                st_q <= (rx.wLength == soc_pkg::LEN_ZERO) ? C_STATUS : C_DATA;
            end
            else if (isAccess)
            begin
                case (stSel)
                    C_DATA:
                    begin
                        if (dataOver)
                        begin
                            tx_q <= mk(soc_pkg::PK_STALL, seq_q, soc_pkg::LEN_ZERO);
                            st_q <= C_STALL;
                        end
                        else if (dirIn_q)
                        begin
                            tx_q <= mk(soc_pkg::PK_DP, seq_q, inLen);
                            remain_q <= remain_q - inLen;
                            shortSent_q <= (inLen < MAX_PKT);
                            seq_q <= soc_pkg::seqNext(seq_q);
                        end
                        else
                        begin
                            tx_q <= mk(soc_pkg::PK_ACK, soc_pkg::seqNext(seq_q), soc_pkg::LEN_ZERO);
                            remain_q <= remain_q - rx.len;
                            seq_q <= soc_pkg::seqNext(seq_q);
                        end
                    end
                    C_STATUS:
                    begin
                        st_q <= C_STATUS;
                        if (rx.kind == soc_pkg::PK_STATUS && rx.deferred)
                            erdyPend_q <= 1'b1;
                        else if (result == soc_pkg::RES_BUSY)
                        begin
                            tx_q <= mk(soc_pkg::PK_NRDY, seq_q, soc_pkg::LEN_ZERO);
                            erdyPend_q <= 1'b1;
                        end
                        else if (result == soc_pkg::RES_ERR)
                        begin
                            tx_q <= mk(soc_pkg::PK_STALL, seq_q, soc_pkg::LEN_ZERO);
                            st_q <= C_STALL;
                        end
                        else
                        begin
                            tx_q <= mk(soc_pkg::PK_ACK, seq_q, soc_pkg::LEN_ZERO);
                            st_q <= C_IDLE;
                        end
                    end
                    C_STALL:
                        tx_q <= mk(soc_pkg::PK_STALL, seq_q, soc_pkg::LEN_ZERO);
                    default:
                        tx_q <= mk(soc_pkg::PK_STALL, seq_q, soc_pkg::LEN_ZERO);
                endcase
            end
            else if (erdyPend_q && !tx_q.vld && ready && result != soc_pkg::RES_BUSY)
            begin
                tx_q <= mk(soc_pkg::PK_ERDY, seq_q, soc_pkg::LEN_ZERO);
                erdyPend_q <= 1'b0;
            end
        end
    end
endmodule : soc_ctl_ep
`default_nettype wire

// >>> src/soc_stream_out.sv
`default_nettype none
module soc_stream_out #(
    parameter logic [4:0] NUMP_OUT = 5'h01,
    parameter logic [15:0] CTL_MAX_PKT = 16'h0200
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic cfg,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire soc_pkg::soc_rx_t rxPkt,
    output soc_pkg::soc_tx_t txPkt
);
    // ------------------------------------------------------------
    // state and wires
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        S_DIS, S_IDLE, S_START, S_START_END, S_PRIME_ACK, S_DEV, S_HOST_TERM,
        S_HOST, S_RETRY, S_ABORT, S_ERDY_START, S_ERDY_ACC
    } soc_sst_t;
    soc_sst_t st_q, st_d;
    logic [15:0] cStream_q, cStream_d;
    logic [4:0] seq_q, seq_d;
    logic startPend_q, abortPend_q;
    soc_pkg::soc_tx_t tx_q, sTx, cTx;
    logic [31:0] ctrlQ, statusWord;
    logic [15:0] ssel, bufSpace, epSize;
    logic startPulse, abortPulse;
    logic [2:0] ctlState;
    logic cGnt, sGnt, sSend;
    logic isDp, isPrime, isNoStream, isRejectDp, moveDp, inMove;

    soc_apb_regs u_regs (
        .mclk(mclk),
        .nrst(nrst),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .statusWord(statusWord),
        .ctrlQ(ctrlQ),
        .ssel(ssel),
        .bufSpace(bufSpace),
        .epSize(epSize),
        .startPulse(startPulse),
        .abortPulse(abortPulse)
    );

    soc_ctl_ep #(
        .MAX_PKT(CTL_MAX_PKT)
    ) u_ctl (
        .mclk(mclk),
        .nrst(nrst),
        .cfg(cfg),
        .rx(rxPkt),
        .hold(ctrlQ[soc_pkg::CTRL_HOLD]),
        .ready(ctrlQ[soc_pkg::CTRL_READY]),
        .result(ctrlQ[soc_pkg::CTRL_RES_LO +: 2]),
        .gnt(cGnt),
        .txReq(cTx),
        .stateCode(ctlState)
    );

    assign statusWord = {9'h000, ctlState, st_q, cStream_q};

    // ------------------------------------------------------------
    // receive decode
    // ------------------------------------------------------------
    assign isDp = rxPkt.vld & ~rxPkt.toCtrl & (rxPkt.kind == soc_pkg::PK_DP);
    assign isPrime = rxPkt.streamId == soc_pkg::SID_PRIME;
    assign isNoStream = rxPkt.streamId == soc_pkg::SID_NOSTREAM;
    assign isRejectDp = isDp & isNoStream & ~rxPkt.pp & (rxPkt.len == soc_pkg::LEN_ZERO);
    assign moveDp = isDp & ~isPrime & ~isNoStream;
    assign inMove = (st_q == S_HOST) | (st_q == S_DEV) | (st_q == S_HOST_TERM);

    // ------------------------------------------------------------
    // transmit select, control end first
    // ------------------------------------------------------------
    assign cGnt = cTx.vld & ~tx_q.vld;
    assign sGnt = sSend & ~cTx.vld & ~tx_q.vld;

    always_comb
    begin
        sTx = '0;
        sTx.vld = 1'b1;
        sTx.streamId = cStream_q;
        sTx.kind = soc_pkg::PK_ACK;
        sTx.seq = seq_q;
        sTx.numP = soc_pkg::NUMP_ZERO;
        sSend = 1'b1;
        case (st_q)
            S_START_END:
            begin
                sTx.kind = soc_pkg::PK_NRDY;
                sTx.streamId = soc_pkg::SID_NOSTREAM;
            end
            S_PRIME_ACK:
            begin
                sTx.kind = soc_pkg::PK_NRDY;
                sTx.streamId = soc_pkg::SID_PRIME;
            end
            S_DEV:
            begin
                if (bufSpace >= epSize)
                    sTx.numP = NUMP_OUT;
            end
            S_RETRY:
            begin
                sTx.numP = NUMP_OUT;
                sTx.rty = 1'b1;
            end
            S_ABORT, S_ERDY_ACC, S_ERDY_START:
            begin
                sTx.kind = (st_q == S_ABORT) ? soc_pkg::PK_NRDY : soc_pkg::PK_ERDY;
                sTx.numP = (st_q == S_ERDY_START) ? NUMP_OUT : soc_pkg::NUMP_ZERO;
            end
            S_HOST_TERM:
                sTx.numP = soc_pkg::NUMP_ZERO;
            default:
            begin
                sTx.vld = 1'b0;
                sSend = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // stream state machine
    // ------------------------------------------------------------
    always_comb
    begin
        st_d = st_q;
        cStream_d = cStream_q;
        seq_d = seq_q;
        case (st_q)
            S_DIS:
            begin
                if (isDp && isPrime)
                    st_d = rxPkt.hubDefer ? S_IDLE : S_PRIME_ACK;
            end
            S_IDLE, S_START, S_HOST:
            begin
                if (isDp && isPrime && st_q != S_HOST)
                    st_d = rxPkt.hubDefer ? S_IDLE : S_PRIME_ACK;
                else if (st_q == S_START && isRejectDp)
                    st_d = S_START_END;
                else if (moveDp)
                begin
                    cStream_d = rxPkt.streamId;
                    if (rxPkt.hubDefer)
                        st_d = ctrlQ[soc_pkg::CTRL_ACCEPT] ? S_ERDY_ACC : S_IDLE;
                    else if (abortPend_q)
                        st_d = S_ABORT;
                    else if (rxPkt.err)
                        st_d = S_RETRY;
                    else
                    begin
                        seq_d = soc_pkg::seqNext(seq_q);
                        st_d = rxPkt.pp ? S_DEV : S_HOST_TERM;
                    end
                end
                else if (st_q == S_HOST && abortPend_q)
                    st_d = S_ABORT;
                else if (st_q == S_IDLE && startPend_q)
                begin
                    cStream_d = ssel;
                    st_d = S_ERDY_START;
                end
            end
            S_DEV:
            begin
                if (sGnt)
                    st_d = abortPend_q ? S_ABORT : (bufSpace >= epSize) ? S_HOST : S_IDLE;
            end
            S_RETRY:
            begin
                if (sGnt)
                    st_d = S_HOST;
            end
            S_ERDY_START:
            begin
                if (sGnt)
                    st_d = S_START;
            end
            S_START_END, S_PRIME_ACK, S_ABORT, S_ERDY_ACC, S_HOST_TERM:
            begin
                if (sGnt)
                    st_d = S_IDLE;
            end
            default:
                st_d = S_DIS;
        endcase
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_q <= S_DIS;
            cStream_q <= soc_pkg::SID_NOSTREAM;
            seq_q <= soc_pkg::SEQ_ZERO;
        end
        else if (cfg)
        begin
            st_q <= S_DIS;
            cStream_q <= soc_pkg::SID_NOSTREAM;
            seq_q <= soc_pkg::SEQ_ZERO;
        end
        else
        begin
            st_q <= st_d;
            cStream_q <= cStream_d;
            seq_q <= seq_d;
        end
    end

    // pending software requests, a new request wins over consumption
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            startPend_q <= 1'b0;
            abortPend_q <= 1'b0;
        end
        else
        begin
            startPend_q <= startPulse | (startPend_q & ~(st_d == S_ERDY_START) & ~cfg);
            abortPend_q <= abortPulse | (abortPend_q & ~(st_q == S_ABORT) & inMoveOrIdle());
        end
    end

    function automatic logic inMoveOrIdle();
        inMoveOrIdle = ~cfg & (inMove | (st_q == S_IDLE) | (st_q == S_START));
    endfunction : inMoveOrIdle

    // ------------------------------------------------------------
    // output register
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            tx_q <= '0;
        else if (cGnt)
            tx_q <= cTx;
        else if (sGnt)
            tx_q <= sTx;
        else
            tx_q <= '0;
    end

    assign txPkt = tx_q;
endmodule : soc_stream_out
`default_nettype wire

// >>> sim/soc_stream_out_props.sv
`default_nettype none
module soc_stream_out_props (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire soc_pkg::soc_rx_t rxPkt,
    input wire soc_pkg::soc_tx_t txPkt
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    sequence s_dp;
        rxPkt.vld && !rxPkt.toCtrl && rxPkt.kind == soc_pkg::PK_DP;
    endsequence
    sequence s_ctl;
        txPkt.vld && txPkt.toCtrl;
    endsequence
    property p_dir;
        s_ctl |-> txPkt.dir == soc_pkg::DIR_CTRL;
    endproperty
    a_dir: assert property (p_dir) else $error("control dir not zero");
    property p_nump;
        s_ctl and txPkt.kind == soc_pkg::PK_ACK |-> txPkt.numP == soc_pkg::NUMP_ZERO;
    endproperty
    a_nump: assert property (p_nump) else $error("control ack numP not zero");
    property p_sid;
        s_dp |-> ##2 (!(txPkt.vld && !txPkt.toCtrl) ||
            txPkt.streamId == $past(rxPkt.streamId, 2));
    endproperty
    a_sid: assert property (p_sid) else $error("stream id mismatch");
    property p_rty;
        s_dp and rxPkt.err |-> ##2 txPkt.vld && txPkt.rty && txPkt.numP != 5'h00;
    endproperty
    a_rty: assert property (p_rty) else $error("no retry ack");
    property p_hub;
        s_dp and rxPkt.hubDefer |-> ##2 !(txPkt.vld && txPkt.kind != soc_pkg::PK_ERDY);
    endproperty
    a_hub: assert property (p_hub) else $error("reply to deferred dp");
    property p_setup;
        rxPkt.vld && rxPkt.toCtrl && rxPkt.setup |->
            ##2 (s_ctl and txPkt.kind == soc_pkg::PK_ACK);
    endproperty
    a_setup: assert property (p_setup) else $error("setup not acked");
    property p_rdy;
        psel && !penable |=> pready;
    endproperty
    a_rdy: assert property (p_rdy) else $error("apb no ready");
    property p_err;
        pslverr |-> pready && $past(psel);
    endproperty
    a_err: assert property (p_err) else $error("stray slave error");
endmodule : soc_stream_out_props
bind soc_stream_out soc_stream_out_props u_props (.mclk, .nrst, .psel, .penable, .pready,
    .pslverr, .rxPkt, .txPkt);
`default_nettype wire

// >>> sim/soc_host_model.sv
`default_nettype none
module soc_host_model (
    input wire logic mclk,
    output soc_pkg::soc_rx_t rxPkt
);
    timeunit 1ns;
    timeprecision 1ps;
    initial rxPkt = '0;
    // f is {hubDefer, pp, err, setup, deferred}
    task dp(input logic c, input soc_pkg::soc_pkt_t k, input logic [15:0] s,
        input logic [4:0] f);
        soc_pkg::soc_rx_t p;
        p = '0;
        p.vld = 1'b1;
        p.kind = k;
        p.toCtrl = c;
        p.streamId = s;
        {p.hubDefer, p.pp, p.err, p.setup, p.deferred} = f;
        p.len = p.setup ? soc_pkg::SETUP_LEN :
            (s == soc_pkg::SID_NOSTREAM) ? soc_pkg::LEN_ZERO : 16'h0200;
        p.seq = soc_pkg::SEQ_ZERO;
        @(posedge mclk);
        rxPkt <= p;
        @(posedge mclk);
        rxPkt <= {1'b0, ~p[$bits(p)-2:0]};
    endtask : dp
endmodule : soc_host_model
`default_nettype wire

// >>> sim/soc_stream_out_tb.sv
`default_nettype none
module soc_stream_out_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [4:0] NP = 5'h03;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic cfg = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [31:0] q;
    logic e;
    soc_pkg::soc_rx_t rxPkt;
    soc_pkg::soc_tx_t txPkt;
    int n_fail = 0;
    int n_checks = 0;
    always #2 mclk = ~mclk;
    soc_stream_out #(.NUMP_OUT(NP)) u_dut (.mclk(mclk), .nrst(nrst), .cfg(cfg), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rxPkt(rxPkt), .txPkt(txPkt));
    soc_host_model u_host (.mclk(mclk), .rxPkt(rxPkt));
    task stop_test;
        if (n_fail == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : stop_test
    task chk(input logic [31:0] g, input logic [31:0] x);
        n_checks++;
        if (g !== x)
        begin
            n_fail++;
            $display("wrong value at %0t: got %h want %h", $time, g, x);
        end
    endtask : chk
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            chk(32'h0, 32'h1);
            stop_test();
        end
    endtask : apb
    // x is {dir, kind, numP, rty, streamId}; control masks the stream id
    task rsp(input logic [25:0] x, input logic c);
        int n;
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (txPkt.vld !== 1'b1 && n < 20);
        if (txPkt.vld !== 1'b1)
        begin
            chk(32'h0, 32'h1);
            stop_test();
        end
        chk({c ? txPkt.dir : 1'b0, txPkt.kind, txPkt.numP, txPkt.rty,
            c ? 16'h0000 : txPkt.streamId}, {6'h00, x});
    endtask : rsp
    initial
    begin
        repeat (16) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        cfg <= 1'b1;
        @(posedge mclk);
        cfg <= 1'b0;
        apb(1'b1, soc_pkg::REG_BUF, 32'h0000_0400);
        apb(1'b1, soc_pkg::REG_EPSZ, 32'h0000_0200);
        apb(1'b0, soc_pkg::REG_BUF, 32'h0);
        chk(q, 32'h0000_0400);
        apb(1'b0, 8'h20, 32'h0);
        chk(q, 32'h0);
        chk({31'h0, e}, 32'h1);
        u_host.dp(1'b0, soc_pkg::PK_DP, soc_pkg::SID_PRIME, 5'h00);
        rsp({1'b0, soc_pkg::PK_NRDY, 5'h00, 1'b0, soc_pkg::SID_PRIME}, 1'b0);
        u_host.dp(1'b0, soc_pkg::PK_DP, 16'h0005, 5'h08);
        rsp({1'b0, soc_pkg::PK_ACK, NP, 1'b0, 16'h0005}, 1'b0);
        u_host.dp(1'b0, soc_pkg::PK_DP, 16'h0005, 5'h04);
        rsp({1'b0, soc_pkg::PK_ACK, NP, 1'b1, 16'h0005}, 1'b0);
        u_host.dp(1'b0, soc_pkg::PK_DP, 16'h0005, 5'h00);
        rsp({1'b0, soc_pkg::PK_ACK, 5'h00, 1'b0, 16'h0005}, 1'b0);
        u_host.dp(1'b0, soc_pkg::PK_DP, 16'h0007, 5'h18);
        apb(1'b1, soc_pkg::REG_BUF, 32'h0000_0100);
        u_host.dp(1'b0, soc_pkg::PK_DP, 16'h0006, 5'h08);
        rsp({1'b0, soc_pkg::PK_ACK, 5'h00, 1'b0, 16'h0006}, 1'b0);
        apb(1'b1, soc_pkg::REG_CTRL, 32'h0000_0004);
        u_host.dp(1'b0, soc_pkg::PK_DP, 16'h0009, 5'h18);
        rsp({1'b0, soc_pkg::PK_ERDY, 5'h00, 1'b0, 16'h0009}, 1'b0);
        apb(1'b1, soc_pkg::REG_CTRL, 32'h0000_0002);
        u_host.dp(1'b0, soc_pkg::PK_DP, 16'h000A, 5'h08);
        rsp({1'b0, soc_pkg::PK_NRDY, 5'h00, 1'b0, 16'h000A}, 1'b0);
        apb(1'b1, soc_pkg::REG_SSEL, 32'h0000_000C);
        apb(1'b1, soc_pkg::REG_CTRL, 32'h0000_0001);
        rsp({1'b0, soc_pkg::PK_ERDY, NP, 1'b0, 16'h000C}, 1'b0);
        u_host.dp(1'b0, soc_pkg::PK_DP, soc_pkg::SID_NOSTREAM, 5'h00);
        rsp({1'b0, soc_pkg::PK_NRDY, 5'h00, 1'b0, soc_pkg::SID_NOSTREAM}, 1'b0);
        apb(1'b1, soc_pkg::REG_CTRL, 32'h0000_0050);
        u_host.dp(1'b1, soc_pkg::PK_DP, 16'h0000, 5'h02);
        rsp({1'b0, soc_pkg::PK_ACK, 5'h00, 1'b0, 16'h0}, 1'b1);
        repeat (2)
        begin
            u_host.dp(1'b1, soc_pkg::PK_STATUS, 16'h0000, 5'h00);
            rsp({1'b0, soc_pkg::PK_STALL, 5'h00, 1'b0, 16'h0}, 1'b1);
        end
        apb(1'b1, soc_pkg::REG_CTRL, 32'h0000_0040);
        u_host.dp(1'b1, soc_pkg::PK_DP, 16'h0000, 5'h02);
        rsp({1'b0, soc_pkg::PK_ACK, 5'h00, 1'b0, 16'h0}, 1'b1);
        u_host.dp(1'b1, soc_pkg::PK_STATUS, 16'h0000, 5'h00);
        rsp({1'b0, soc_pkg::PK_ACK, 5'h00, 1'b0, 16'h0}, 1'b1);
        apb(1'b1, soc_pkg::REG_CTRL, 32'h0000_0028);
        u_host.dp(1'b1, soc_pkg::PK_DP, 16'h0000, 5'h02);
        rsp({1'b0, soc_pkg::PK_ACK, 5'h00, 1'b0, 16'h0}, 1'b1);
        apb(1'b1, soc_pkg::REG_CTRL, 32'h0000_0040);
        rsp({1'b0, soc_pkg::PK_ERDY, 5'h00, 1'b0, 16'h0}, 1'b1);
        u_host.dp(1'b1, soc_pkg::PK_STATUS, 16'h0000, 5'h01);
        rsp({1'b0, soc_pkg::PK_ERDY, 5'h00, 1'b0, 16'h0}, 1'b1);
        apb(1'b1, soc_pkg::REG_CTRL, 32'h0000_0060);
        u_host.dp(1'b1, soc_pkg::PK_STATUS, 16'h0000, 5'h00);
        rsp({1'b0, soc_pkg::PK_NRDY, 5'h00, 1'b0, 16'h0}, 1'b1);
        apb(1'b1, soc_pkg::REG_CTRL, 32'h0000_0040);
        rsp({1'b0, soc_pkg::PK_ERDY, 5'h00, 1'b0, 16'h0}, 1'b1);
        u_host.dp(1'b1, soc_pkg::PK_STATUS, 16'h0000, 5'h00);
        rsp({1'b0, soc_pkg::PK_ACK, 5'h00, 1'b0, 16'h0}, 1'b1);
        stop_test();
    end
endmodule : soc_stream_out_tb
`default_nettype wire
